//--- stsq_top.sv
// scan trigger sequencer: trigger sources, pass stepping and run control
// Notes on behaviour
// - five trigger sources: periodic, key, external edge, calendar, alarm.
// - periodic pass longer than interval: passes run back to back, no error.
// - interval zero to 99:59:59.999 in one millisecond steps.
// - count unlimited or 1..50000; finite periodic run halts by itself.
// - unlimited periodic run repeats until a long-press stop.
// - key mode: first press runs a pass, later presses each one more.
// - key mode finite count: leave waiting when triggers served equal count.
// - external mode reacts only to the chosen edge, one trigger each.
// - external, calendar, alarm: start only enters waiting; events start passes.
// - external finite count: leave waiting after that many triggers.
// - calendar match starts a pass; a match during a pass is discarded.
// - calendar target fields range checked, day by month; invalid rejected.
// - wildcarded calendar fields are left out of the comparison.
// - all fields wildcarded: calendar mode triggers continuously.
// - calendar finite count: leave waiting after that many matches.
// - alarm mode: only the selected source's new alarm starts a pass.
// - alarm finite count: leave waiting after that many alarm triggers.
// - every pass stores results into non-volatile storage unasked.
// - each pass visits listed slots in ascending order, slot 0 to slot 4.
// - while active, modules with a listed channel are locked.
// - long press ends scanning and waiting; no resume, only a fresh start.
// - a new run first clears the reading memory.
// - interval runs start to start; its default is zero.
// - alarm source selectable among four alarm outputs.
`timescale 1ns/1ns
module stsq_top #(
  parameter int unsigned MS_CYCLES = stsq_pkg::MS_CYCLES_DFLT
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic start_req_i,
  input wire logic stop_req_i,
  input wire logic ext_trig_i,
  input wire logic ext_rising_i,
  input wire stsq_pkg::stsq_mode_t trig_mode_i,
  input wire stsq_pkg::stsq_interval_t interval_i,
  input wire logic count_unlimited_i,
  input wire logic [15:0] scan_count_i,
  input wire logic cal_load_i,
  input wire stsq_pkg::stsq_cal_t cal_target_i,
  input wire stsq_pkg::stsq_wild_t cal_wild_i,
  input wire stsq_pkg::stsq_cal_t sys_time_i,
  input wire logic [3:0] alarm_event_i,
  input wire logic [1:0] alarm_sel_i,
  input wire logic [4:0] slot_listed_i,
  input wire logic slot_done_i,
  output logic slot_req_o,
  output logic [2:0] slot_o,
  output logic store_en_o,
  output logic mem_clear_o,
  output logic scanning_o,
  output logic waiting_o,
  output logic [4:0] slot_lock_o,
  output logic [15:0] served_o,
  output logic cal_reject_o
);
  import stsq_pkg::*;

  stsq_state_t state_ff;
  stsq_state_t nxt_state;
  stsq_mode_t mode_ff;
  logic unlimited_ff;
  logic [15:0] limit_ff;
  logic [15:0] served_ff;
  logic [4:0] list_ff;
  logic [2:0] slot_ff;
  logic pend_ff;
  logic slot_req_ff;
  logic mem_clear_ff;
  logic [15:0] presc_ff;
  logic [28:0] elapsed_ff;
  logic [28:0] interval_ms_ff;
  stsq_cal_t cal_ff;
  stsq_wild_t wild_ff;
  logic cal_reject_ff;
  logic cal_hit_ff;
  logic ext_pulse;
  logic ms_tick;
  logic pass_start;
  logic pass_end;
  logic last_served;
  logic trig_evt;
  logic cal_hit;
  logic cal_evt;
  logic all_wild;
  logic cal_ok;
  logic [4:0] day_lim;
  logic [15:0] nxt_limit;
  logic [6:0] iv_h;
  logic [5:0] iv_m;
  logic [5:0] iv_s;
  logic [9:0] iv_ms;

  // external trigger input conditioning
  stsq_edge_sync u_ext (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(ext_trig_i),
    .rising_i(ext_rising_i),
    .pulse_o(ext_pulse)
  );

  // millisecond prescaler, restarted with each pass so intervals stay exact
  assign ms_tick = (presc_ff == 16'(MS_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_ff <= 16'h0000;
    end else if (ms_tick || pass_start) begin
      presc_ff <= 16'h0000;
    end else begin
      presc_ff <= presc_ff + 16'h0001;
    end
  end

  // clamp interval fields to their legal ranges
  always_comb begin
    iv_h = (interval_i.hours > IV_HOUR_MAX) ? IV_HOUR_MAX : interval_i.hours;
    iv_m = (interval_i.minutes > IV_MIN_MAX) ? IV_MIN_MAX
                                             : interval_i.minutes;
    iv_s = (interval_i.seconds > IV_SEC_MAX) ? IV_SEC_MAX
                                             : interval_i.seconds;
    iv_ms = (interval_i.millis > IV_MS_MAX) ? IV_MS_MAX : interval_i.millis;
  end

  // interval converted to whole milliseconds, reset value zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interval_ms_ff <= '0;
    end else begin
      interval_ms_ff <= 29'(iv_h * MS_PER_HOUR)
                      + 29'(iv_m * MS_PER_MIN)
                      + 29'(iv_s * MS_PER_SEC)
                      + 29'(iv_ms);
    end
  end

  // time since the start of the last pass, saturating
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      elapsed_ff <= '0;
    end else if (pass_start) begin
      elapsed_ff <= '0;
    end else if (ms_tick && elapsed_ff != ELAPSED_MAX) begin
      elapsed_ff <= elapsed_ff + ELAPSED_STEP;
    end
  end

  // day limit for the target month; wildcard month allows the longest
  always_comb begin
    if (cal_wild_i.month) begin
      day_lim = DAYS_LONG;
    end else if (cal_target_i.month == MONTH_FEB) begin
      day_lim = DAYS_FEB;
    end else if (cal_target_i.month == MONTH_APR ||
                 cal_target_i.month == MONTH_JUN ||
                 cal_target_i.month == MONTH_SEP ||
                 cal_target_i.month == MONTH_NOV) begin
      day_lim = DAYS_SHORT;
    end else begin
      day_lim = DAYS_LONG;
    end
  end

  // every non-wildcard field must lie in range
  assign cal_ok =
    (cal_wild_i.month || (cal_target_i.month >= MONTH_MIN &&
                          cal_target_i.month <= MONTH_MAX)) &&
    (cal_wild_i.day || (cal_target_i.day >= DAY_MIN &&
                        cal_target_i.day <= day_lim)) &&
    (cal_wild_i.hour || cal_target_i.hour <= HOUR_MAX) &&
    (cal_wild_i.minute || cal_target_i.minute <= MINUTE_MAX) &&
    (cal_wild_i.second || cal_target_i.second <= SECOND_MAX);

  // calendar target store; invalid loads leave the old target
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_ff <= '0;
      wild_ff <= '1;
      cal_reject_ff <= 1'b0;
    end else if (cal_load_i) begin
      cal_reject_ff <= ~cal_ok;
      if (cal_ok) begin
        cal_ff <= cal_target_i;
        wild_ff <= cal_wild_i;
      end
    end
  end

  // masked compare against system time
  assign cal_hit =
    (wild_ff.month || cal_ff.month == sys_time_i.month) &&
    (wild_ff.day || cal_ff.day == sys_time_i.day) &&
    (wild_ff.hour || cal_ff.hour == sys_time_i.hour) &&
    (wild_ff.minute || cal_ff.minute == sys_time_i.minute) &&
    (wild_ff.second || cal_ff.second == sys_time_i.second);
  assign all_wild = &wild_ff;

  // a match counts once, when it first appears, unless every field is wildcarded
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_hit_ff <= 1'b0;
    end else begin
      cal_hit_ff <= cal_hit;
    end
  end
  assign cal_evt = (cal_hit & ~cal_hit_ff) | all_wild;

  // trigger event for the current mode, only honoured while waiting
  always_comb begin
    case (mode_ff)
      TRIG_PERIODIC: trig_evt = elapsed_ff >= interval_ms_ff;
      TRIG_KEY: trig_evt = start_req_i;
      TRIG_EXT: trig_evt = ext_pulse;
      TRIG_CAL: trig_evt = cal_evt;
      TRIG_ALARM: trig_evt = alarm_event_i[alarm_sel_i];
      default: trig_evt = 1'b0;
    endcase
  end

  // pass ends after the last slot is done or skipped
  assign pass_end = (state_ff == ST_RUN) && (slot_ff == SLOT_LAST) &&
                    (!list_ff[slot_ff] || (pend_ff && slot_done_i));
  assign last_served = !unlimited_ff &&
                       (served_ff + 16'h0001 == limit_ff);

  // run state machine
  always_comb begin
    nxt_state = state_ff;
    pass_start = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_req_i) begin
          nxt_state = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        if (mode_ff == TRIG_PERIODIC || mode_ff == TRIG_KEY) begin
          nxt_state = ST_RUN;
          pass_start = 1'b1;
        end else begin
          nxt_state = ST_WAIT;
        end
      end
      ST_RUN: begin
        if (pass_end) begin
          if (last_served) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (trig_evt) begin
          nxt_state = ST_RUN;
          pass_start = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (stop_req_i) begin
      nxt_state = ST_IDLE;
      pass_start = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // count limit held in range
  always_comb begin
    if (scan_count_i < COUNT_MIN) begin
      nxt_limit = COUNT_MIN;
    end else if (scan_count_i > COUNT_MAX) begin
      nxt_limit = COUNT_MAX;
    end else begin
      nxt_limit = scan_count_i;
    end
  end

  // run settings captured at start so they cannot shift mid-run
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_ff <= TRIG_PERIODIC;
      unlimited_ff <= 1'b1;
      limit_ff <= COUNT_MIN;
      list_ff <= '0;
    end else if (state_ff == ST_IDLE && start_req_i && !stop_req_i) begin
      mode_ff <= trig_mode_i;
      unlimited_ff <= count_unlimited_i;
      limit_ff <= nxt_limit;
      list_ff <= slot_listed_i;
    end
  end

  // passes served in this run, reset by a fresh start
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      served_ff <= '0;
    end else if (state_ff == ST_CLEAR) begin
      served_ff <= '0;
    end else if (pass_end && !stop_req_i) begin
      served_ff <= served_ff + 16'h0001;
    end
  end

  // reading memory clear pulse at run start
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_clear_ff <= 1'b0;
    end else begin
      mem_clear_ff <= (state_ff == ST_IDLE) && start_req_i &&
                      !stop_req_i;
    end
  end

  // slot stepping: ascending, unlisted slots skipped
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_ff <= SLOT_FIRST;
      pend_ff <= 1'b0;
      slot_req_ff <= 1'b0;
    end else begin
      slot_req_ff <= 1'b0;
      if (pass_start || nxt_state != ST_RUN) begin
        slot_ff <= SLOT_FIRST;
        pend_ff <= 1'b0;
      end else if (!list_ff[slot_ff]) begin
        slot_ff <= slot_ff + 3'h1;
      end else if (!pend_ff) begin
        pend_ff <= 1'b1;
        slot_req_ff <= 1'b1;
      end else if (slot_done_i) begin
        pend_ff <= 1'b0;
        slot_ff <= slot_ff + 3'h1;
      end
    end
  end

  // status and storage strobes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      store_en_o <= 1'b0;
      scanning_o <= 1'b0;
      waiting_o <= 1'b0;
      slot_lock_o <= '0;
    end else begin
      store_en_o <= nxt_state == ST_RUN;
      scanning_o <= nxt_state != ST_IDLE;
      waiting_o <= nxt_state == ST_WAIT;
      slot_lock_o <= (nxt_state == ST_IDLE) ? '0 :
                     (state_ff == ST_IDLE) ? slot_listed_i : list_ff;
    end
  end

  assign slot_req_o = slot_req_ff;
  assign slot_o = slot_ff;
  assign mem_clear_o = mem_clear_ff;
  assign served_o = served_ff;
  assign cal_reject_o = cal_reject_ff;

endmodule

//--- stsq_pkg.sv
// shared types and constants of the scan trigger sequencer
package stsq_pkg;

  // five trigger sources
  typedef enum logic [2:0] {
    TRIG_PERIODIC = 3'h0,
    TRIG_KEY = 3'h1,
    TRIG_EXT = 3'h2,
    TRIG_CAL = 3'h3,
    TRIG_ALARM = 3'h4
  } stsq_mode_t;

  // run states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CLEAR = 2'h1,
    ST_RUN = 2'h2,
    ST_WAIT = 2'h3
  } stsq_state_t;

  // periodic interval, hour:minute:second.millisecond
  typedef struct packed {
    logic [6:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [9:0] millis;
  } stsq_interval_t;

  // calendar time, plain binary fields
  typedef struct packed {
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } stsq_cal_t;

  // wildcard flags, one per calendar field
  typedef struct packed {
    logic month;
    logic day;
    logic hour;
    logic minute;
    logic second;
  } stsq_wild_t;

  // timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned STEP_MS = 1;
  localparam int unsigned MS_CYCLES_DFLT = CLK_HZ / 1000 * STEP_MS;

  // interval limits and scale
  localparam logic [6:0] IV_HOUR_MAX = 7'h63;
  localparam logic [5:0] IV_MIN_MAX = 6'h3B;
  localparam logic [5:0] IV_SEC_MAX = 6'h3B;
  localparam logic [9:0] IV_MS_MAX = 10'h3E7;
  localparam logic [28:0] MS_PER_HOUR = 29'h036EE80;
  localparam logic [28:0] MS_PER_MIN = 29'h000EA60;
  localparam logic [28:0] MS_PER_SEC = 29'h00003E8;
  localparam logic [28:0] ELAPSED_MAX = 29'h1FFFFFFF;
  localparam logic [28:0] ELAPSED_STEP = 29'h0000001;

  // scan count limits
  localparam logic [15:0] COUNT_MIN = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hC350;

  // channel list
  localparam int unsigned NUM_SLOTS = 5;
  localparam int unsigned NUM_ALARMS = 4;
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h4;

  // calendar limits
  localparam logic [3:0] MONTH_MIN = 4'h1;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [3:0] MONTH_FEB = 4'h2;
  localparam logic [3:0] MONTH_APR = 4'h4;
  localparam logic [3:0] MONTH_JUN = 4'h6;
  localparam logic [3:0] MONTH_SEP = 4'h9;
  localparam logic [3:0] MONTH_NOV = 4'hB;
  localparam logic [4:0] DAY_MIN = 5'h01;
  localparam logic [4:0] DAYS_LONG = 5'h1F;
  localparam logic [4:0] DAYS_SHORT = 5'h1E;
  localparam logic [4:0] DAYS_FEB = 5'h1D;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] MINUTE_MAX = 6'h3B;
  localparam logic [5:0] SECOND_MAX = 6'h3B;

endpackage

//--- stsq_edge_sync.sv
// external trigger synchroniser with selectable edge detection
`timescale 1ns/1ns
module stsq_edge_sync (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  input wire logic rising_i,
  output logic pulse_o
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic pulse_ff;
  logic nxt_pulse;

  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  // chosen transition gives one single-cycle pulse
  always_comb begin
    if (rising_i) begin
      nxt_pulse = sync_ff & ~prev_ff;
    end else begin
      nxt_pulse = ~sync_ff & prev_ff;
    end
  end

  // edge history and registered pulse
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      prev_ff <= sync_ff;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse_o = pulse_ff;

endmodule

//--- stsq_top_assertions.sv
// port checker of the scan trigger sequencer, bound to its top module
`timescale 1ns/1ns
module stsq_top_chk
  import stsq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic start_req_i,
  input wire logic stop_req_i,
  input wire stsq_pkg::stsq_mode_t trig_mode_i,
  input wire logic cal_load_i,
  input wire stsq_pkg::stsq_cal_t cal_target_i,
  input wire stsq_pkg::stsq_wild_t cal_wild_i,
  input wire logic [4:0] slot_listed_i,
  input wire logic slot_req_o,
  input wire logic [2:0] slot_o,
  input wire logic store_en_o,
  input wire logic mem_clear_o,
  input wire logic scanning_o,
  input wire logic waiting_o,
  input wire logic [4:0] slot_lock_o,
  input wire logic [15:0] served_o,
  input wire logic cal_reject_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [2:0] last_slot_ff;
  logic have_ff;
  logic [15:0] srv_ff;
  // remember the last slot requested within the current pass
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_slot_ff <= 3'h0;
      have_ff <= 1'b0;
      srv_ff <= 16'h0000;
    end else begin
      srv_ff <= served_o;
      if (served_o != srv_ff || !scanning_o) begin
        have_ff <= 1'b0;
      end else if (slot_req_o) begin
        have_ff <= 1'b1;
        last_slot_ff <= slot_o;
      end
    end
  end
  property p_start; start_req_i && !stop_req_i && !scanning_o |=>
    mem_clear_o && scanning_o; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_clear; mem_clear_o |=> !mem_clear_o; endproperty
  a_clear: assert property (p_clear) else $error("clear too long");
  property p_stop; stop_req_i |=> !scanning_o && !waiting_o && !slot_req_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not obeyed");
  property p_idle; !scanning_o && !$past(scanning_o) |->
    slot_lock_o == 5'h00 && !store_en_o; endproperty
  a_idle: assert property (p_idle) else $error("lock while idle");
  property p_req; slot_req_o |-> store_en_o && slot_lock_o[slot_o];
  endproperty
  a_req: assert property (p_req) else $error("request outside pass");
  property p_wait; waiting_o |-> scanning_o && !slot_req_o; endproperty
  a_wait: assert property (p_wait) else $error("pass while waiting");
  property p_served; served_o != $past(served_o) |->
    served_o == $past(served_o) + 16'h0001 || served_o == 16'h0000;
  endproperty
  a_served: assert property (p_served) else $error("served jump");
  property p_hour; cal_load_i && !cal_wild_i.hour &&
    cal_target_i.hour > HOUR_MAX |=> cal_reject_o; endproperty
  a_hour: assert property (p_hour) else $error("bad hour kept");
  property p_key; waiting_o && trig_mode_i == TRIG_KEY && start_req_i &&
    !stop_req_i && slot_listed_i != 5'h00 |-> ##[1:8] slot_req_o;
  endproperty
  a_key: assert property (p_key) else $error("key press ignored");
  property p_order; slot_req_o && have_ff && served_o == srv_ff |->
    slot_o > last_slot_ff; endproperty
  a_order: assert property (p_order) else $error("slot order");
endmodule
bind stsq_top stsq_top_chk stsq_top_chk_inst (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .start_req_i(start_req_i),
  .stop_req_i(stop_req_i), .trig_mode_i(trig_mode_i),
  .cal_load_i(cal_load_i), .cal_target_i(cal_target_i),
  .cal_wild_i(cal_wild_i), .slot_listed_i(slot_listed_i),
  .slot_req_o(slot_req_o), .slot_o(slot_o), .store_en_o(store_en_o),
  .mem_clear_o(mem_clear_o), .scanning_o(scanning_o),
  .waiting_o(waiting_o), .slot_lock_o(slot_lock_o),
  .served_o(served_o), .cal_reject_o(cal_reject_o));

//--- stsq_operator_model.sv
// operator start/stop key and external trigger source
`timescale 1ns/1ns
module stsq_operator_model (
  input wire logic core_clk_i,
  output logic start_req_o,
  output logic stop_req_o,
  output logic ext_trig_o
);
  // all lines idle low until used
  initial begin
    start_req_o = 1'b0;
    stop_req_o = 1'b0;
    ext_trig_o = 1'b0;
  end
  // short press: one clock wide start pulse
  task press_start;
    @(negedge core_clk_i);
    start_req_o = 1'b1;
    @(negedge core_clk_i);
    start_req_o = 1'b0;
  endtask
  // long press: one clock wide stop pulse
  task press_stop;
    @(negedge core_clk_i);
    stop_req_o = 1'b1;
    @(negedge core_clk_i);
    stop_req_o = 1'b0;
  endtask
  // external source moves its pin, unrelated to any edge of interest
  task set_pin(input logic v);
    @(negedge core_clk_i);
    ext_trig_o = v;
  endtask
endmodule

//--- stsq_top_tb_top.sv
// self-checking testbench of the scan trigger sequencer
`timescale 1ns/1ns
module stsq_top_tb_top;
  import stsq_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_req, stop_req, ext_trig;
  logic ext_rising_i = 1'b0;
  stsq_mode_t trig_mode_i = TRIG_PERIODIC;
  stsq_interval_t interval_i = '0;
  logic count_unlimited_i = 1'b0;
  logic [15:0] scan_count_i = 16'h0001;
  logic cal_load_i = 1'b0;
  stsq_cal_t cal_target_i = '0;
  stsq_wild_t cal_wild_i = 5'h1F;
  stsq_cal_t sys_time_i = '0;
  logic [3:0] alarm_event_i = 4'h0;
  logic [1:0] alarm_sel_i = 2'h0;
  logic [4:0] slot_listed_i = 5'h01;
  logic slot_done_i = 1'b0;
  logic slot_req_o, store_en_o, mem_clear_o, scanning_o, waiting_o;
  logic cal_reject_o;
  logic [2:0] slot_o;
  logic [4:0] slot_lock_o;
  logic [15:0] served_o;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int done_dly = 0;
  int pend_cnt = 0;
  bit pend = 0;
  int seen_q[$];
  int start_q[$];
  always #20 core_clk_i = ~core_clk_i;
  stsq_operator_model stsq_operator_model_inst (.core_clk_i(core_clk_i),
    .start_req_o(start_req), .stop_req_o(stop_req), .ext_trig_o(ext_trig));
  stsq_top #(.MS_CYCLES(4)) stsq_top_inst (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .start_req_i(start_req), .stop_req_i(stop_req),
    .ext_trig_i(ext_trig), .ext_rising_i(ext_rising_i),
    .trig_mode_i(trig_mode_i), .interval_i(interval_i),
    .count_unlimited_i(count_unlimited_i), .scan_count_i(scan_count_i),
    .cal_load_i(cal_load_i), .cal_target_i(cal_target_i),
    .cal_wild_i(cal_wild_i), .sys_time_i(sys_time_i),
    .alarm_event_i(alarm_event_i), .alarm_sel_i(alarm_sel_i),
    .slot_listed_i(slot_listed_i), .slot_done_i(slot_done_i),
    .slot_req_o(slot_req_o), .slot_o(slot_o), .store_en_o(store_en_o),
    .mem_clear_o(mem_clear_o), .scanning_o(scanning_o),
    .waiting_o(waiting_o), .slot_lock_o(slot_lock_o),
    .served_o(served_o), .cal_reject_o(cal_reject_o));
  // scan engine stand-in: logs requests, answers after done_dly cycles
  always @(negedge core_clk_i) begin
    slot_done_i <= 1'b0;
    if (slot_req_o === 1'b1) begin
      seen_q.push_back(slot_o);
      start_q.push_back(cyc);
      pend = 1;
      pend_cnt = done_dly;
    end
    if (pend && pend_cnt == 0) begin
      slot_done_i <= 1'b1;
      pend = 0;
    end else if (pend) begin
      pend_cnt--;
    end
  end
  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task cycles(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  function automatic bit hit(input int k, input int n);
    case (k)
      0: return scanning_o === 1'b0;
      1: return waiting_o === 1'b1;
      default: return served_o >= n;
    endcase
  endfunction
  // wait for idle (0), waiting (1) or n passes served (2), bounded
  task wait_for(input int k, input int n);
    for (int i = 0; i < 3000 && !hit(k, n); i++) @(negedge core_clk_i);
  endtask
  task start_run(input stsq_mode_t m, input logic unl, input int n);
    trig_mode_i = m;
    count_unlimited_i = unl;
    scan_count_i = n[15:0];
    seen_q.delete();
    start_q.delete();
    stsq_operator_model_inst.press_start();
    check("mem_clear_o", mem_clear_o, 1);
  endtask
  task cal_load(input stsq_cal_t t, input stsq_wild_t w, input logic rej);
    cal_target_i = t;
    cal_wild_i = w;
    cal_load_i = 1'b1;
    cycles(1);
    cal_load_i = 1'b0;
    cycles(1);
    check("cal_reject_o", cal_reject_o, rej);
  endtask
  task pulse_alarm(input logic [3:0] v);
    alarm_event_i = v;
    cycles(1);
    alarm_event_i = 4'h0;
  endtask
  task t_interval;
    interval_i = '{millis: 10'h002, default: '0};
    slot_listed_i = 5'h10;
    start_run(TRIG_PERIODIC, 1'b0, 2);
    wait_for(0, 0);
    check("served_o", served_o, 2);
    check("slot_o", seen_q[0], 4);
    check("gap", (start_q[1] - start_q[0]) inside {[8:12]}, 1);
  endtask
  task t_back2back;
    interval_i = '{millis: 10'h001, default: '0};
    slot_listed_i = 5'h15;
    done_dly = 3;
    start_run(TRIG_PERIODIC, 1'b0, 2);
    wait_for(0, 0);
    check("served_o", served_o, 2);
    check("requests", seen_q.size(), 6);
    foreach (seen_q[i]) check("slot_o", seen_q[i], (i % 3) * 2);
    done_dly = 0;
  endtask
  task t_stop;
    interval_i = '0;
    slot_listed_i = 5'h01;
    start_run(TRIG_PERIODIC, 1'b1, 1);
    wait_for(2, 3);
    check("served_o", served_o >= 3, 1);
    stsq_operator_model_inst.press_stop();
    cycles(2);
    check("scanning_o", scanning_o, 0);
    check("served_o", seen_q.size(), served_o);
  endtask
  task t_key;
    slot_listed_i = 5'h03;
    start_run(TRIG_KEY, 1'b0, 2);
    wait_for(1, 0);
    check("served_o", served_o, 1);
    check("slot_lock_o", slot_lock_o, 5'h03);
    stsq_operator_model_inst.press_start();
    wait_for(0, 0);
    check("served_o", served_o, 2);
  endtask
  task t_ext;
    for (int p = 0; p < 2; p++) begin
      ext_rising_i = p[0];
      stsq_operator_model_inst.set_pin(p[0]);
      cycles(8);
      start_run(TRIG_EXT, !p[0], 1);
      wait_for(1, 0);
      stsq_operator_model_inst.set_pin(!p[0]);
      cycles(12);
      check("served_o", served_o, 0);
      stsq_operator_model_inst.set_pin(p[0]);
      wait_for(2, 1);
      check("waiting_o", waiting_o, !p[0]);
      check("served_o", served_o, 1);
      stsq_operator_model_inst.press_stop();
      cycles(2);
      check("waiting_o", waiting_o, 0);
    end
  endtask
  task t_cal;
    cal_load('{hour: 5'h18, month: 4'h1, day: 5'h01, default: '0}, 5'h00, 1);
    cal_load('{month: 4'h2, day: 5'h1E, default: '0}, 5'h00, 1);
    cal_load('{second: 6'h05, default: '0}, 5'h1E, 0);
    start_run(TRIG_CAL, 1'b0, 2);
    wait_for(1, 0);
    cycles(10);
    check("served_o", served_o, 0);
    done_dly = 3;
    sys_time_i.second = 6'h05;
    cycles(3);
    sys_time_i.second = 6'h06;
    cycles(1);
    sys_time_i.second = 6'h05;
    wait_for(1, 0);
    cycles(10);
    check("served_o", served_o, 1);
    sys_time_i.second = 6'h00;
    cycles(1);
    sys_time_i.second = 6'h05;
    wait_for(0, 0);
    check("served_o", served_o, 2);
    done_dly = 0;
    sys_time_i.second = 6'h00;
    cal_load('{second: 6'h05, default: '0}, 5'h1F, 0);
    start_run(TRIG_CAL, 1'b0, 2);
    wait_for(0, 0);
    check("served_o", served_o, 2);
  endtask
  task t_alarm;
    alarm_sel_i = 2'h2;
    start_run(TRIG_ALARM, 1'b0, 1);
    wait_for(1, 0);
    pulse_alarm(4'h1);
    cycles(10);
    check("served_o", served_o, 0);
    pulse_alarm(4'h4);
    wait_for(0, 0);
    check("served_o", served_o, 1);
  endtask
  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (20) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    cycles(1);
    t_interval();
    t_back2back();
    t_stop();
    t_key();
    t_ext();
    t_cal();
    t_alarm();
    finish_test();
  end
endmodule
